// ### rtl/bwhl_top.sv
`timescale 1ns/1ps
`include "bwhl_defs.svh"
// Behaviour
// - At most three near branches per window
// - Straddling branch belongs to later window
// - Split taken-predicted branch dispatches alone
// - Limit covers near jumps, calls, returns
// - Fourth branch in window stays unpredicted
// - Only taken branches get history entries
// - Ordinary code stores leave lines modified
// - Lines modified at the fetch request written back before instruction fill
// - Streaming code stores bypass cache allocation
module bwhl_top
	import bwhl_pkg::*;
(
	input wire logic clock, // Core clock, 100 MHz
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic fetch_valid, // Fetch request, held until ready
	input wire logic [`BWHL_ADDR_W-1:0] fetch_addr, // Fetch byte address
	output logic fetch_ready, // Fetch line delivered
	output logic fetch_miss, // Fetch hit a modified line
	output logic pred_valid, // Prediction result pulse
	output logic pred_hit, // A tracked branch ahead in window
	output logic [3:0] pred_off, // End-byte offset of that branch
	output logic [`BWHL_ADDR_W-1:0] pred_target, // Its target
	input wire logic res_valid, // Branch resolve pulse
	input wire logic [`BWHL_ADDR_W-1:0] res_addr, // First byte of branch
	input wire logic [3:0] res_len, // Branch length, 1 to 15
	input wire bwhl_kind_t res_kind, // Branch form
	input wire logic res_taken, // Branch resolved taken
	input wire logic [`BWHL_ADDR_W-1:0] res_target, // Resolved target
	output logic res_dropped, // Branch refused, window full
	input wire logic dec_valid, // Decoded branch at dispatch
	input wire logic [`BWHL_ADDR_W-1:0] dec_addr, // Its first byte
	input wire logic [3:0] dec_len, // Its length
	input wire logic dec_pred_taken, // Predicted taken
	output logic dec_solo, // Dispatch it alone
	input wire logic st_valid, // Store of instruction bytes
	input wire logic [`BWHL_ADDR_W-1:0] st_addr, // Store address
	input wire logic st_stream, // Write-combining store
	output logic st_ready, // Store accepted
	output logic wb_valid, // Write-back request
	output logic [`BWHL_LINE_W-1:0] wb_line, // Write-back line
	input wire logic wb_ready, // Write-back taken
	output logic icf_valid, // Instruction fill request
	output logic [`BWHL_LINE_W-1:0] icf_line, // Fill line
	input wire logic icf_done // Fill complete
);
	bwhl_cache_if cif ();

	bwhl_slot_t slot_w [`BWHL_SETS][`BWHL_SLOTS];
	logic [`BWHL_TAG_W-1:0] tag_w [`BWHL_SETS];
	logic set_vld_w [`BWHL_SETS];

	logic [`BWHL_ADDR_W-1:0] res_end;
	logic [`BWHL_ADDR_W-`BWHL_WIN_LSB-1:0] res_win;
	logic [`BWHL_SET_BITS-1:0] rset, fset;
	logic [`BWHL_TAG_W-1:0] rtag, ftag;
	logic [3:0] roff;
	logic res_cross, tracked, tag_hit, off_found, free_found;
	logic [1:0] hit_idx, free_idx;
	logic upd_ok, upd_new, upd_alloc, upd_drop;
	logic dec_split;
	logic look_hit;
	logic [3:0] look_off;
	logic [`BWHL_ADDR_W-1:0] look_tgt;
	logic pred_valid_reg, pred_hit_reg, res_dropped_reg, dec_solo_reg;
	logic [3:0] pred_off_reg;
	logic [`BWHL_ADDR_W-1:0] pred_target_reg;
	logic [`BWHL_SET_BITS-1:0] chk_set_reg;
	logic [`BWHL_TAG_W-1:0] chk_tag_reg;
	logic chk_vld_reg;
	bwhl_slot_t [`BWHL_SLOTS-1:0] rset_slots, chk_slots, chk_slots_reg;

	// Attribute the branch to the window of its last byte
	assign res_end = res_addr + {28'h0, res_len} - 32'h1;
	assign res_cross = res_end[`BWHL_ADDR_W-1:`BWHL_WIN_LSB] !=
		res_addr[`BWHL_ADDR_W-1:`BWHL_WIN_LSB];
	assign res_win = res_end[`BWHL_ADDR_W-1:`BWHL_WIN_LSB];
	assign rset = res_win[`BWHL_SET_BITS-1:0];
	assign rtag = res_win[`BWHL_ADDR_W-`BWHL_WIN_LSB-1:`BWHL_SET_BITS];
	assign roff = res_end[3:0];
	// Far transfers are outside the limit; all near forms count
	assign tracked = (res_kind != bwhl_far_xfer);

	// Slot search within the attributed window
	always_comb begin
		tag_hit = set_vld_w[rset] && (tag_w[rset] == rtag);
		off_found = 1'b0;
		free_found = 1'b0;
		hit_idx = '0;
		free_idx = '0;
		for (int k = `BWHL_SLOTS - 1; k >= 0; k--) begin
			if (slot_w[rset][k].vld && (slot_w[rset][k].off == roff)) begin
				off_found = 1'b1;
				hit_idx = 2'(k);
			end
			if (!slot_w[rset][k].vld) begin
				free_found = 1'b1;
				free_idx = 2'(k);
			end
		end
	end

	// Never-taken branches never reach the store
	assign upd_ok = res_valid && res_taken && tracked;
	assign upd_new = upd_ok && !tag_hit;
	assign upd_alloc = upd_ok && tag_hit && !off_found && free_found;
	assign upd_drop = upd_ok && tag_hit && !off_found && !free_found;

	// One history set per window index; a new window evicts the old one whole
	generate
		for (genvar g = 0; g < `BWHL_SETS; g++) begin : g_set
			bwhl_slot_t slot_reg [`BWHL_SLOTS];
			logic [`BWHL_TAG_W-1:0] tag_reg;
			logic vld_reg;
			assign slot_w[g] = slot_reg;
			assign tag_w[g] = tag_reg;
			assign set_vld_w[g] = vld_reg;
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					vld_reg <= 1'b0;
					tag_reg <= '0;
					for (int k = 0; k < `BWHL_SLOTS; k++) begin
						slot_reg[k] <= '0;
					end
				end else if (upd_ok && (rset == `BWHL_SET_BITS'(g))) begin
					if (upd_new) begin
						vld_reg <= 1'b1;
						tag_reg <= rtag;
						slot_reg[0] <= '{vld: 1'b1, off: roff, tgt: res_target};
						for (int k = 1; k < `BWHL_SLOTS; k++) begin
							slot_reg[k].vld <= 1'b0;
						end
					end else if (off_found) begin
						slot_reg[hit_idx].tgt <= res_target;
					end else if (free_found) begin
						slot_reg[free_idx] <= '{vld: 1'b1, off: roff, tgt: res_target};
					end
				end
			end
		end
	endgenerate

	// Excess branch is refused and reported, the window keeps its three
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			res_dropped_reg <= 1'b0;
		end else begin
			res_dropped_reg <= upd_drop;
		end
	end

	// Nearest tracked branch at or after the fetch offset
	assign fset = fetch_addr[`BWHL_WIN_LSB+`BWHL_SET_BITS-1:`BWHL_WIN_LSB];
	assign ftag = fetch_addr[`BWHL_ADDR_W-1:`BWHL_WIN_LSB+`BWHL_SET_BITS];
	always_comb begin
		look_hit = 1'b0;
		look_off = '0;
		look_tgt = '0;
		if (set_vld_w[fset] && (tag_w[fset] == ftag)) begin
			for (int k = 0; k < `BWHL_SLOTS; k++) begin
				if (slot_w[fset][k].vld && (slot_w[fset][k].off >= fetch_addr[3:0]) &&
					(!look_hit || (slot_w[fset][k].off < look_off))) begin
					look_hit = 1'b1;
					look_off = slot_w[fset][k].off;
					look_tgt = slot_w[fset][k].tgt;
				end
			end
		end
	end

	// Prediction is registered the cycle after the line arrives
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pred_valid_reg <= 1'b0;
			pred_hit_reg <= 1'b0;
			pred_off_reg <= '0;
			pred_target_reg <= '0;
		end else begin
			pred_valid_reg <= fetch_valid && cif.fch_ready;
			if (fetch_valid && cif.fch_ready) begin
				pred_hit_reg <= look_hit;
				pred_off_reg <= look_off;
				pred_target_reg <= look_tgt;
			end
		end
	end

	// Split branch predicted taken cannot share a dispatch group
	assign dec_split = ({1'b0, dec_addr[3:0]} + {1'b0, dec_len}) > `BWHL_WIN_BYTES;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			dec_solo_reg <= 1'b0;
		end else begin
			dec_solo_reg <= dec_valid && dec_split && dec_pred_taken;
		end
	end

	// Line request waits on write-back of modified data
	assign cif.fch_valid = fetch_valid;
	assign cif.fch_line = fetch_addr[`BWHL_ADDR_W-1:`BWHL_LINE_LSB];

	bwhl_cache_ctl u_cache (
		.clock(clock),
		.sys_rst(sys_rst),
		.cif(cif),
		.st_valid(st_valid),
		.st_line(st_addr[`BWHL_ADDR_W-1:`BWHL_LINE_LSB]),
		.st_stream(st_stream),
		.st_ready(st_ready),
		.wb_valid(wb_valid),
		.wb_line(wb_line),
		.wb_ready(wb_ready),
		.icf_valid(icf_valid),
		.icf_line(icf_line),
		.icf_done(icf_done)
	);

	assign fetch_ready = cif.fch_ready;
	assign fetch_miss = cif.fch_miss;
	assign pred_valid = pred_valid_reg;
	assign pred_hit = pred_hit_reg;
	assign pred_off = pred_off_reg;
	assign pred_target = pred_target_reg;
	assign res_dropped = res_dropped_reg;
	assign dec_solo = dec_solo_reg;

	// Slots of the resolved window now, and of last cycle's window
	always_comb begin
		for (int k = 0; k < `BWHL_SLOTS; k++) begin
			rset_slots[k] = slot_w[rset][k];
			chk_slots[k] = slot_w[chk_set_reg][k];
		end
	end

	// Snapshot so a check can see that a refused resolve left the set alone
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			chk_set_reg <= '0;
			chk_vld_reg <= 1'b0;
			chk_tag_reg <= '0;
			chk_slots_reg <= '0;
		end else begin
			chk_set_reg <= rset;
			chk_vld_reg <= set_vld_w[rset];
			chk_tag_reg <= tag_w[rset];
			chk_slots_reg <= rset_slots;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	slot_limit_a: assert property (upd_drop |=> chk_slots == chk_slots_reg)
		else $error("full window changed on a refused branch");
	split_attr_a: assert property (res_valid && res_cross |->
		res_win == res_addr[`BWHL_ADDR_W-1:`BWHL_WIN_LSB] + 28'h1)
		else $error("straddling branch not in later window");
	solo_split_a: assert property (dec_valid && dec_split && dec_pred_taken |=> dec_solo)
		else $error("split taken branch not dispatched alone");
	solo_cause_a: assert property ($rose(dec_solo) |->
		$past(dec_pred_taken) && $past(dec_valid))
		else $error("solo dispatch without taken prediction");
	far_skip_a: assert property (res_valid && res_kind == bwhl_far_xfer |=>
		!res_dropped && set_vld_w[chk_set_reg] == chk_vld_reg &&
		tag_w[chk_set_reg] == chk_tag_reg && chk_slots == chk_slots_reg)
		else $error("far transfer entered history");
	excess_drop_a: assert property (1'b1 |=> res_dropped == $past(upd_drop))
		else $error("fourth branch not refused");
	taken_only_a: assert property (res_valid && !res_taken |=> !res_dropped &&
		set_vld_w[chk_set_reg] == chk_vld_reg && tag_w[chk_set_reg] == chk_tag_reg &&
		chk_slots == chk_slots_reg)
		else $error("never-taken branch allocated");
	pred_lat_a: assert property (fetch_valid && fetch_ready |=> pred_valid ##1 !pred_valid)
		else $error("prediction not one cycle after fetch");

	full_cover_c: cover property (upd_alloc ##[1:40] upd_drop);
	split_cover_c: cover property (dec_solo);
	pred_cover_c: cover property (pred_valid && pred_hit);
endmodule

// ### rtl/bwhl_defs.svh
`ifndef BWHL_DEFS_SVH
`define BWHL_DEFS_SVH
// Fetch address width in bits
`define BWHL_ADDR_W 32
// Fetch window is 16 bytes, so the window index starts at bit 4
`define BWHL_WIN_LSB 4
`define BWHL_WIN_BYTES 5'h10
// History slots per fetch window
`define BWHL_SLOTS 3
// Window sets held in the history store
`define BWHL_SET_BITS 4
`define BWHL_SETS 16
`define BWHL_TAG_W 24
// Cache line is 64 bytes
`define BWHL_LINE_LSB 6
`define BWHL_LINE_W 26
// Modified-line tracker depth
`define BWHL_MOD_DEPTH 8
`define BWHL_MOD_IDX_W 3
`endif

// ### rtl/bwhl_pkg.sv
package bwhl_pkg;
	// Branch forms seen at resolve; only far transfers are untracked
	typedef enum logic [2:0] {
		bwhl_jcc_rel,
		bwhl_jmp_rel,
		bwhl_jmp_reg,
		bwhl_jmp_mem,
		bwhl_call_rel,
		bwhl_call_ind,
		bwhl_ret_near,
		bwhl_far_xfer
	} bwhl_kind_t;

	// One history slot: end-byte offset in the window and target
	typedef struct packed {
		logic vld;
		logic [3:0] off;
		logic [31:0] tgt;
	} bwhl_slot_t;

	// Instruction fetch line control states
	typedef enum logic [1:0] {
		bwhl_cst_idle,
		bwhl_cst_wb,
		bwhl_cst_fill
	} bwhl_cst_t;
endpackage

// ### rtl/bwhl_cache_if.sv
`timescale 1ns/1ps
`include "bwhl_defs.svh"
// Fetch line request from the history block to the line control
interface bwhl_cache_if;
	logic fch_valid;
	logic [`BWHL_LINE_W-1:0] fch_line;
	logic fch_ready;
	logic fch_miss;
	modport fetch (output fch_valid, output fch_line, input fch_ready, input fch_miss);
	modport cache (input fch_valid, input fch_line, output fch_ready, output fch_miss);
endinterface

// ### rtl/bwhl_cache_ctl.sv
`timescale 1ns/1ps
`include "bwhl_defs.svh"
module bwhl_cache_ctl
	import bwhl_pkg::*;
(
	input wire logic clock, // Core clock
	input wire logic sys_rst, // Synchronous reset
	bwhl_cache_if.cache cif, // Fetch line request
	input wire logic st_valid, // Store of instruction bytes
	input wire logic [`BWHL_LINE_W-1:0] st_line, // Store line address
	input wire logic st_stream, // Store is write-combining
	output logic st_ready, // Store accepted
	output logic wb_valid, // Write-back request to memory
	output logic [`BWHL_LINE_W-1:0] wb_line, // Write-back line
	input wire logic wb_ready, // Memory took write-back
	output logic icf_valid, // Instruction cache fill request
	output logic [`BWHL_LINE_W-1:0] icf_line, // Fill line
	input wire logic icf_done // Fill complete
);
	bwhl_cst_t state_reg;
	logic [`BWHL_LINE_W-1:0] line_reg;
	logic [`BWHL_MOD_IDX_W-1:0] wb_idx_reg;
	logic [`BWHL_MOD_DEPTH-1:0] mod_vld, f_match, s_match, mod_set;
	logic [`BWHL_MOD_IDX_W-1:0] f_idx, free_idx;
	logic f_any, s_any, free_any, st_mark, clr_go;

	// Ordinary stores mark lines modified; streaming ones leave the tracker alone
	assign st_mark = st_valid && !st_stream && (s_any || free_any);
	assign st_ready = st_stream || s_any || free_any;
	assign clr_go = (state_reg == bwhl_cst_wb) && wb_ready;

	// Per-entry modified flag; a store to the line wins over its clear
	generate
		for (genvar e = 0; e < `BWHL_MOD_DEPTH; e++) begin : g_mod
			logic vld_reg;
			logic [`BWHL_LINE_W-1:0] line_e_reg;
			assign f_match[e] = vld_reg && (line_e_reg == cif.fch_line);
			assign s_match[e] = vld_reg && (line_e_reg == st_line);
			assign mod_set[e] = st_mark && (s_any ? s_match[e] : (free_idx == `BWHL_MOD_IDX_W'(e)));
			assign mod_vld[e] = vld_reg;
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					vld_reg <= 1'b0;
					line_e_reg <= '0;
				end else if (mod_set[e]) begin
					vld_reg <= 1'b1;
					line_e_reg <= st_line;
				end else if (clr_go && (wb_idx_reg == `BWHL_MOD_IDX_W'(e))) begin
					vld_reg <= 1'b0;
				end
			end
		end
	endgenerate

	// Lookup of fetch hit and first free entry
	always_comb begin
		f_any = 1'b0;
		f_idx = '0;
		s_any = |s_match;
		free_any = 1'b0;
		free_idx = '0;
		for (int e = `BWHL_MOD_DEPTH - 1; e >= 0; e--) begin
			if (f_match[e]) begin
				f_any = 1'b1;
				f_idx = `BWHL_MOD_IDX_W'(e);
			end
			if (!mod_vld[e]) begin
				free_any = 1'b1;
				free_idx = `BWHL_MOD_IDX_W'(e);
			end
		end
	end

	// A line already modified at the fetch request is written back before its fill
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= bwhl_cst_idle;
			line_reg <= '0;
			wb_idx_reg <= '0;
		end else begin
			unique case (state_reg)
				bwhl_cst_idle: begin
					if (cif.fch_valid) begin
						line_reg <= cif.fch_line;
						wb_idx_reg <= f_idx;
						state_reg <= f_any ? bwhl_cst_wb : bwhl_cst_fill;
					end
				end
				bwhl_cst_wb: begin
					if (wb_ready) begin
						state_reg <= bwhl_cst_fill;
					end
				end
				bwhl_cst_fill: begin
					if (icf_done) begin
						state_reg <= bwhl_cst_idle;
					end
				end
			endcase
		end
	end

	assign cif.fch_miss = (state_reg == bwhl_cst_idle) && cif.fch_valid && f_any;
	assign cif.fch_ready = (state_reg == bwhl_cst_fill) && icf_done;
	assign wb_valid = (state_reg == bwhl_cst_wb);
	assign icf_valid = (state_reg == bwhl_cst_fill);
	assign wb_line = line_reg;
	assign icf_line = line_reg;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	dirty_miss_a: assert property (cif.fch_miss |=> wb_valid [*1] ##1 (wb_valid || icf_valid))
		else $error("modified line not written back first");
	wb_then_fill_a: assert property (wb_valid && wb_ready |=> icf_valid && !wb_valid)
		else $error("fill did not follow write-back");
	store_marks_a: assert property (st_valid && !st_stream && !s_any && free_any |=>
		mod_vld != $past(mod_vld))
		else $error("ordinary store did not mark a line");
	stream_bypass_a: assert property (st_valid && st_stream && !clr_go |=> $stable(mod_vld))
		else $error("streaming store changed cache state");
	dirty_cover_c: cover property (cif.fch_miss ##[1:20] cif.fch_ready);
endmodule

// ### testbench/bwhl_mem_model.sv
`timescale 1ns/1ps
`include "bwhl_defs.svh"
// Memory side of the line control: takes write-backs, serves fills
module bwhl_mem_model (
	input wire logic clock, // Core clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic [1:0] lat, // Wait cycles before each answer
	input wire logic wb_valid, // Write-back request
	input wire logic [`BWHL_LINE_W-1:0] wb_line, // Write-back line
	output logic wb_ready, // Write-back taken
	input wire logic icf_valid, // Fill request
	output logic icf_done, // Fill complete
	output logic [7:0] wb_cnt, // Write-backs taken so far
	output logic [`BWHL_LINE_W-1:0] wb_last // Last line written back
);
	logic [1:0] wait_reg;
	initial begin
		wb_ready = 1'b0;
		icf_done = 1'b0;
	end
	// Answers move off the sampling edge; each is a one-cycle pulse
	always @(negedge clock) begin
		wb_ready <= 1'b0;
		icf_done <= 1'b0;
		if (sys_rst) begin
			wait_reg <= 2'h0;
			wb_cnt <= 8'h00;
			wb_last <= '0;
		end else if (wb_valid && !wb_ready) begin
			if (wait_reg == lat) begin
				wb_ready <= 1'b1;
				wb_cnt <= wb_cnt + 8'h01;
				wb_last <= wb_line;
				wait_reg <= 2'h0;
			end else wait_reg <= wait_reg + 2'h1;
		end else if (icf_valid && !icf_done) begin
			// Fill only after the write-back, never alongside it
			if (wait_reg == lat) begin
				icf_done <= 1'b1;
				wait_reg <= 2'h0;
			end else wait_reg <= wait_reg + 2'h1;
		end
	end
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
`include "bwhl_defs.svh"
`define CHK(g, e) check_val(64'(g), 64'(e))
module tb;
	import bwhl_pkg::*;
	logic clock, sys_rst, fetch_valid, res_valid, res_taken, dec_valid, dec_pred_taken;
	logic st_valid, st_stream, fetch_ready, fetch_miss, pred_valid, pred_hit;
	logic res_dropped, dec_solo, st_ready, wb_valid, wb_ready, icf_valid, icf_done;
	logic [31:0] fetch_addr, res_addr, res_target, dec_addr, st_addr, pred_target;
	logic [3:0] res_len, dec_len, pred_off;
	logic [`BWHL_LINE_W-1:0] wb_line, icf_line, wb_last;
	logic [7:0] wb_cnt;
	logic [1:0] lat;
	bwhl_kind_t res_kind;
	int error_cnt, samples_checked;

	bwhl_top dut (.clock(clock), .sys_rst(sys_rst), .fetch_valid(fetch_valid),
		.fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .fetch_miss(fetch_miss),
		.pred_valid(pred_valid), .pred_hit(pred_hit), .pred_off(pred_off),
		.pred_target(pred_target), .res_valid(res_valid), .res_addr(res_addr),
		.res_len(res_len), .res_kind(res_kind), .res_taken(res_taken),
		.res_target(res_target), .res_dropped(res_dropped), .dec_valid(dec_valid),
		.dec_addr(dec_addr), .dec_len(dec_len), .dec_pred_taken(dec_pred_taken),
		.dec_solo(dec_solo), .st_valid(st_valid), .st_addr(st_addr),
		.st_stream(st_stream), .st_ready(st_ready), .wb_valid(wb_valid),
		.wb_line(wb_line), .wb_ready(wb_ready), .icf_valid(icf_valid),
		.icf_line(icf_line), .icf_done(icf_done));

	bwhl_mem_model mem (.clock(clock), .sys_rst(sys_rst), .lat(lat),
		.wb_valid(wb_valid), .wb_line(wb_line), .wb_ready(wb_ready),
		.icf_valid(icf_valid), .icf_done(icf_done), .wb_cnt(wb_cnt), .wb_last(wb_last));

	// 100 MHz core clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Case equality so an unknown never passes
	task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("Mismatches %0d, checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic bail();
		error_cnt++;
		$display("Wait limit reached at t=%0t", $time);
		stop_test();
	endtask

	// Inputs move at the falling edge, outputs are read just before the rising one
	task automatic do_fetch(input logic [31:0] a, input logic em, input logic eh,
		input logic [3:0] eo, input logic [31:0] et);
		int n;
		logic miss;
		@(negedge clock);
		fetch_valid = 1'b1;
		fetch_addr = a;
		#4 miss = fetch_miss;
		n = 0;
		while (fetch_ready !== 1'b1) begin
			@(negedge clock);
			#4 n++;
			if (n > 50) bail();
		end
		`CHK(icf_line, a[31:6]);
		@(negedge clock);
		fetch_valid = 1'b0;
		#4 `CHK(pred_valid, 1'b1);
		`CHK(miss, em);
		`CHK(pred_hit, eh);
		if (eh) begin
			`CHK(pred_off, eo);
			`CHK(pred_target, et);
		end
	endtask

	task automatic do_res(input logic [31:0] a, input logic [3:0] len, input bwhl_kind_t k,
		input logic tk, input logic [31:0] t, input logic ed);
		@(negedge clock);
		res_valid = 1'b1;
		res_addr = a;
		res_len = len;
		res_kind = k;
		res_taken = tk;
		res_target = t;
		@(negedge clock);
		res_valid = 1'b0;
		#4 `CHK(res_dropped, ed);
	endtask

	task automatic do_dec(input logic [31:0] a, input logic [3:0] len, input logic pt,
		input logic es);
		@(negedge clock);
		dec_valid = 1'b1;
		dec_addr = a;
		dec_len = len;
		dec_pred_taken = pt;
		@(negedge clock);
		dec_valid = 1'b0;
		#4 `CHK(dec_solo, es);
	endtask

	task automatic do_st(input logic [31:0] a, input logic s);
		int n;
		@(negedge clock);
		st_valid = 1'b1;
		st_addr = a;
		st_stream = s;
		#4 n = 0;
		while (st_ready !== 1'b1) begin
			@(negedge clock);
			#4 n++;
			if (n > 50) bail();
		end
		@(negedge clock);
		st_valid = 1'b0;
	endtask

	// Three tracked forms per window, fourth refused, untracked ones ignored
	task automatic sc_window_limit();
		for (int i = 0; i < 7; i++) begin
			do_res(32'h2000 + (i / 3) * 16 + (i % 3) * 4, 4'h2, bwhl_kind_t'(i), 1'b1,
				32'h8000 + i, 1'b0);
		end
		do_res(32'h200c, 4'h2, bwhl_jcc_rel, 1'b0, 32'h9000, 1'b0);
		do_res(32'h200e, 4'h2, bwhl_far_xfer, 1'b1, 32'h9001, 1'b0);
		do_res(32'h200e, 4'h2, bwhl_call_rel, 1'b1, 32'h9002, 1'b1);
		do_res(32'h2008, 4'h2, bwhl_jmp_rel, 1'b1, 32'h9003, 1'b0);
		do_fetch(32'h2000, 1'b0, 1'b1, 4'h1, 32'h8000);
		do_fetch(32'h2005, 1'b0, 1'b1, 4'h5, 32'h8001);
		do_fetch(32'h2009, 1'b0, 1'b1, 4'h9, 32'h9003);
		do_fetch(32'h200a, 1'b0, 1'b0, 4'h0, 32'h0);
		do_fetch(32'h2016, 1'b0, 1'b1, 4'h9, 32'h8005);
		do_fetch(32'h2020, 1'b0, 1'b1, 4'h1, 32'h8006);
	endtask

	// Branch across a window edge counts in the later window
	task automatic sc_straddle();
		do_res(32'h300e, 4'h4, bwhl_jcc_rel, 1'b1, 32'h7777, 1'b0);
		do_fetch(32'h3010, 1'b0, 1'b1, 4'h1, 32'h7777);
		do_fetch(32'h3000, 1'b0, 1'b0, 4'h0, 32'h0);
	endtask

	// Split and predicted taken goes alone; ending on the edge is not split
	task automatic sc_solo();
		do_dec(32'h000e, 4'h4, 1'b1, 1'b1);
		do_dec(32'h000e, 4'h4, 1'b0, 1'b0);
		do_dec(32'h000c, 4'h4, 1'b1, 1'b0);
		do_dec(32'h001d, 4'h4, 1'b1, 1'b1);
	endtask

	// Slow memory: modified line written back before fill, streaming leaves it clean
	task automatic sc_stores();
		logic [7:0] n0;
		lat = 2'h2;
		n0 = wb_cnt;
		do_st(32'h4010, 1'b0);
		do_fetch(32'h4000, 1'b1, 1'b0, 4'h0, 32'h0);
		`CHK(wb_cnt, n0 + 8'h01);
		`CHK(wb_last, 26'h0000100);
		do_fetch(32'h4020, 1'b0, 1'b0, 4'h0, 32'h0);
		do_st(32'h5000, 1'b1);
		do_fetch(32'h5000, 1'b0, 1'b0, 4'h0, 32'h0);
		`CHK(wb_cnt, n0 + 8'h01);
		lat = 2'h0;
	endtask

	initial begin
		error_cnt = 0;
		samples_checked = 0;
		{fetch_valid, res_valid, res_taken, dec_valid, dec_pred_taken} = 5'h00;
		{st_valid, st_stream} = 2'h0;
		{fetch_addr, res_addr, res_target, dec_addr, st_addr} = '0;
		res_len = 4'h1;
		dec_len = 4'h1;
		res_kind = bwhl_jcc_rel;
		lat = 2'h0;
		sys_rst = 1'b1;
		repeat (5) @(negedge clock);
		sys_rst = 1'b0;
		sc_window_limit();
		sc_straddle();
		sc_solo();
		sc_stores();
		stop_test();
	end
endmodule
